// file: verilog/adcrd_path.sv
// Summary of operation
// - Results of both converters and of the step filter can be moved to memory by DMA.
// - A DMA path writes memory words into the two converter control registers only.
// - The DMA read path takes words straight from either result register or the step result.
// - Each converter yields a 24-bit result, twos complement or unipolar per the coding bit.
// - One result count equals Vref/2^28, signed in bipolar and positive-only in unipolar.
// - Hardware removes the amplifier gain from the stored result.
// - Reading a result register clears that converter's ready flag.
// - A set ready flag blocks new data from overwriting that result register.
// - In power-down with DMA enabled the block is lifted and the newest result is kept.
// - The error bit sets on a gross overflow or underflow beyond 30 percent of full scale.
// - With the repeat counter active, results update only when the limit is reached.
// - While the processor is off, repeat gating is lifted so results stay current.
// - Simultaneous sampling copies the second converter's filter and start to the first.
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Shared constants
// ****************************************************************
package adcrd_pkg;
  localparam int NCH = 3;                 // Two converters plus step filter
  localparam int NCONV = 2;               // Converters with control registers
  localparam int STEP_CH = 2;             // Index of the step-filter channel
  localparam int RAW_W = 26;              // Raw modulator word with headroom
  localparam int RES_W = 32;              // Result register width
  localparam int CTRL_W = 20;             // Control register width
  localparam int FLT_W = 16;              // Filter setting width
  localparam int RCR_W = 16;              // Repeat-count width
  localparam int GAIN_W = 3;              // Log2 of amplifier gain
  localparam int CODING_BIT = 18;         // Unipolar when set
  localparam int SIM_BIT = 15;            // Simultaneous sampling enable
  localparam int ALIGN_SHIFT = 4;         // 24-bit code onto the 2^28 scale
  localparam logic [CTRL_W-1:0] CTRL0_RST = 20'h3038C;
  localparam logic [CTRL_W-1:0] CTRL1_RST = 20'h303FF;
  localparam logic [RES_W-1:0] RES_RST = 32'h00000000;
  localparam logic [RCR_W-1:0] RCR_RST = 16'h0000;
  localparam logic [RCR_W-1:0] RCR_ONE = 16'h0001;
  localparam logic [FLT_W-1:0] FLT_RST = 16'h0000;
  // Gross limits: more than 30 percent beyond full scale
  localparam logic signed [RAW_W-1:0] BIP_HI = 26'sh0A66666;
  localparam logic signed [RAW_W-1:0] BIP_LO = -26'sh0A66666;
  localparam logic signed [RAW_W-1:0] UNI_HI = 26'sh14CCCCC;
  localparam logic signed [RAW_W-1:0] UNI_LO = -26'sh04CCCCC;
  // Clamp points of the 24-bit code
  localparam logic signed [RAW_W-1:0] BIP_MAX = 26'sh07FFFFF;
  localparam logic signed [RAW_W-1:0] BIP_MIN = -26'sh0800000;
  localparam logic signed [RAW_W-1:0] UNI_MAX = 26'sh0FFFFFF;
  localparam logic signed [RAW_W-1:0] UNI_MIN = 26'sh0000000;
endpackage

module adcrd_path (
  input wire logic sys_clk,                                          // System clock
  input wire logic rst_n,                                            // Async reset, low
  input wire logic [adcrd_pkg::NCH-1:0] raw_valid,                   // Raw word strobes
  input wire logic [adcrd_pkg::NCH-1:0][adcrd_pkg::RAW_W-1:0] raw,   // Raw words
  input wire logic [adcrd_pkg::NCONV-1:0][adcrd_pkg::GAIN_W-1:0] pga_gain, // Gain log2
  input wire logic [adcrd_pkg::NCONV-1:0][adcrd_pkg::RCR_W-1:0] repeat_count_limit, // Limit
  input wire logic [adcrd_pkg::NCONV-1:0][adcrd_pkg::FLT_W-1:0] filter_cfg, // Filter sets
  input wire logic [adcrd_pkg::NCONV-1:0] conv_start_in,             // Start requests
  input wire logic [adcrd_pkg::FLT_W-1:0] common_converter_config,   // Common config
  input wire logic power_down,                                       // Power-down mode
  input wire logic cpu_off,                                          // Processor asleep
  input wire logic rd_strobe,                                        // Processor read
  input wire logic [1:0] rd_sel,                                     // Read channel
  input wire logic [adcrd_pkg::NCONV-1:0] sw_ctrl_we,                // Software write
  input wire logic [adcrd_pkg::CTRL_W-1:0] sw_ctrl_data,             // Software data
  input wire logic [adcrd_pkg::NCH-1:0] dma_rd_en,                   // Result DMA enable
  input wire logic [adcrd_pkg::NCH-1:0] dma_rd_ack,                  // Result word taken
  input wire logic [adcrd_pkg::NCONV-1:0] dma_wr_en,                 // Control DMA enable
  input wire logic [adcrd_pkg::NCONV-1:0] dma_wr_ack,                // Control word given
  input wire logic [adcrd_pkg::CTRL_W-1:0] dma_wr_data,              // Control DMA data
  output logic [adcrd_pkg::NCH-1:0][adcrd_pkg::RES_W-1:0] conversion_result_reg, // Results
  output logic [adcrd_pkg::NCH-1:0] result_ready,                    // Ready flags
  output logic [adcrd_pkg::NCH-1:0] result_error,                    // Error flags
  output logic [adcrd_pkg::RES_W-1:0] rd_data,                       // Read data
  output logic [adcrd_pkg::NCH-1:0] dma_rd_req,                      // Result requests
  output logic [adcrd_pkg::NCONV-1:0] dma_wr_req,                    // Control requests
  output logic [adcrd_pkg::NCONV-1:0][adcrd_pkg::CTRL_W-1:0] converter_control_reg, // Ctrl
  output logic [adcrd_pkg::FLT_W-1:0] filter_applied0,               // First conv filter
  output logic [adcrd_pkg::NCONV-1:0] conv_start_out                 // Applied starts
);
  typedef struct packed {
    logic [adcrd_pkg::NCH-1:0][adcrd_pkg::RES_W-1:0] res;
    logic [adcrd_pkg::NCH-1:0] rdy;
    logic [adcrd_pkg::NCH-1:0] err;
    logic [adcrd_pkg::NCH-1:0] dreq;
    logic [adcrd_pkg::NCONV-1:0] wreq;
    logic [adcrd_pkg::NCONV-1:0][adcrd_pkg::RCR_W-1:0] rcnt;
    logic [adcrd_pkg::NCONV-1:0][adcrd_pkg::CTRL_W-1:0] ctrl;
    logic [adcrd_pkg::RES_W-1:0] rd_data;
    logic [adcrd_pkg::FLT_W-1:0] flt0;
    logic [adcrd_pkg::NCONV-1:0] start;
  } adcrd_state_t;

  adcrd_state_t s_reg;
  adcrd_state_t s_next;
  logic [adcrd_pkg::NCH-1:0] sc_valid;
  logic [adcrd_pkg::NCH-1:0][adcrd_pkg::RES_W-1:0] sc_res;
  logic [adcrd_pkg::NCH-1:0] sc_gross;
  logic [adcrd_pkg::NCH-1:0] coding;
  logic [adcrd_pkg::NCH-1:0][adcrd_pkg::GAIN_W-1:0] gain;
  logic sim_on;

  assign sim_on = common_converter_config[adcrd_pkg::SIM_BIT];

  // ****************************************************************
  // Scalers, one per result channel
  // ****************************************************************
  // The step filter follows the first converter's coding at unity gain
  always_comb
  begin
    coding[0] = s_reg.ctrl[0][adcrd_pkg::CODING_BIT];
    coding[1] = s_reg.ctrl[1][adcrd_pkg::CODING_BIT];
    coding[adcrd_pkg::STEP_CH] = s_reg.ctrl[0][adcrd_pkg::CODING_BIT];
    gain[0] = pga_gain[0];
    gain[1] = pga_gain[1];
    gain[adcrd_pkg::STEP_CH] = '0;
  end

  genvar g;
  generate
    for (g = 0; g < adcrd_pkg::NCH; g++)
    begin : gen_scale
      adcrd_scale u_scale (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .raw_valid(raw_valid[g]),
        .raw(raw[g]),
        .unipolar(coding[g]),
        .gain_log2(gain[g]),
        .res_valid(sc_valid[g]),
        .res(sc_res[g]),
        .gross(sc_gross[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Clears are applied first so a new event in the same cycle wins
  always_comb
  begin
    logic rd_hit;
    logic allow;
    logic rcr_act;
    logic reach;
    logic [adcrd_pkg::RCR_W-1:0] cnt_inc;
    rd_hit = 1'b0;
    allow = 1'b0;
    rcr_act = 1'b0;
    reach = 1'b0;
    cnt_inc = '0;
    s_next = s_reg;
    for (int c = 0; c < adcrd_pkg::NCH; c++)
    begin
      // Select 3 aliases channel 0, so a read there clears that flag too
      rd_hit = (rd_strobe && rd_sel % 2'(adcrd_pkg::NCH) == 2'(c))
        || (s_reg.dreq[c] && dma_rd_ack[c]);
      if (rd_hit)
      begin
        s_next.rdy[c] = 1'b0;
        s_next.err[c] = 1'b0;
        s_next.dreq[c] = 1'b0;
      end
      // Power-down with DMA lifts the overwrite block
      allow = !s_reg.rdy[c] || (power_down && dma_rd_en[c]);
      rcr_act = 1'b0;
      cnt_inc = '0;
      if (c < adcrd_pkg::NCONV)
      begin
        rcr_act = repeat_count_limit[c] > adcrd_pkg::RCR_ONE;
        cnt_inc = s_reg.rcnt[c] + adcrd_pkg::RCR_ONE;
      end
      reach = !rcr_act || cnt_inc >= repeat_count_limit[c % adcrd_pkg::NCONV];
      if (sc_valid[c])
      begin
        if (c < adcrd_pkg::NCONV)
          s_next.rcnt[c] = reach ? adcrd_pkg::RCR_RST : cnt_inc;
        // Processor off: every conversion lands while ready is clear, so data is current on wake
        if (allow && (reach || cpu_off))
          s_next.res[c] = sc_res[c];
        if (allow && reach)
        begin
          s_next.rdy[c] = 1'b1;
          if (dma_rd_en[c])
            s_next.dreq[c] = 1'b1;
        end
      end
      if (sc_gross[c])
        s_next.err[c] = 1'b1;
    end
    // Control word path: software write takes priority over DMA
    for (int c = 0; c < adcrd_pkg::NCONV; c++)
    begin
      s_next.wreq[c] = dma_wr_en[c] && !(s_reg.wreq[c] && dma_wr_ack[c]);
      if (sw_ctrl_we[c])
        s_next.ctrl[c] = sw_ctrl_data;
      else if (s_reg.wreq[c] && dma_wr_ack[c])
        s_next.ctrl[c] = dma_wr_data;
    end
    if (rd_strobe)
      s_next.rd_data = s_reg.res[rd_sel % 2'(adcrd_pkg::NCH)];
    // Paired sampling: first converter borrows the second's setup
    s_next.flt0 = sim_on ? filter_cfg[1] : filter_cfg[0];
    s_next.start[0] = sim_on ? conv_start_in[1] : conv_start_in[0];
    s_next.start[1] = conv_start_in[1];
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_reg <= '0;
      s_reg.ctrl[0] <= adcrd_pkg::CTRL0_RST;
      s_reg.ctrl[1] <= adcrd_pkg::CTRL1_RST;
    end
    else
      s_reg <= s_next;
  end

  // Outputs come straight from the state register
  assign conversion_result_reg = s_reg.res;
  assign result_ready = s_reg.rdy;
  assign result_error = s_reg.err;
  assign rd_data = s_reg.rd_data;
  assign dma_rd_req = s_reg.dreq;
  assign dma_wr_req = s_reg.wreq;
  assign converter_control_reg = s_reg.ctrl;
  assign filter_applied0 = s_reg.flt0;
  assign conv_start_out = s_reg.start;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_ready_blocks_res: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_reg.rdy[0] && !(power_down && dma_rd_en[0]) |=> $stable(s_reg.res[0]))
    else $error("result overwritten while ready");

  a_read_clears_rdy: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_strobe && rd_sel == 2'h0 && !sc_valid[0] |=> !s_reg.rdy[0])
    else $error("read did not clear ready");

  a_dma_req_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_reg.dreq[1] && !dma_rd_ack[1] && !(rd_strobe && rd_sel == 2'h1) |=> s_reg.dreq[1])
    else $error("result request dropped before acknowledge");

  a_gross_sets_err: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sc_gross[0] |=> s_reg.err[0])
    else $error("gross excursion did not set error");

  a_unipolar_positive: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sc_valid[1] && coding[1] |-> !sc_res[1][adcrd_pkg::RES_W-1])
    else $error("unipolar result went negative");

  a_rcr_gates_res: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sc_valid[0] && repeat_count_limit[0] > adcrd_pkg::RCR_ONE && !cpu_off
    && s_reg.rcnt[0] + adcrd_pkg::RCR_ONE < repeat_count_limit[0] |=> $stable(s_reg.res[0]))
    else $error("result updated before repeat limit");

  a_pd_keeps_latest: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sc_valid[0] && power_down && dma_rd_en[0]
    && (cpu_off || repeat_count_limit[0] <= adcrd_pkg::RCR_ONE)
    |=> s_reg.res[0] == $past(sc_res[0]))
    else $error("power-down result not the newest");

  a_sim_filter_copy: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sim_on |=> s_reg.flt0 == $past(filter_cfg[1]) && s_reg.start[0] == $past(conv_start_in[1]))
    else $error("paired sampling setup not copied");

  a_ctrl_dma_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_reg.wreq[0] && dma_wr_ack[0] && !sw_ctrl_we[0] |=> s_reg.ctrl[0] == $past(dma_wr_data))
    else $error("control DMA word not stored");

  a_step_dma_req: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sc_valid[2] && !s_reg.rdy[2] && dma_rd_en[2] |=> s_reg.dreq[2] ##0 s_reg.rdy[2])
    else $error("step result gave no DMA request");

  a_limit_sets_rdy: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sc_valid[0] && !s_reg.rdy[0] && repeat_count_limit[0] > adcrd_pkg::RCR_ONE
    && s_reg.rcnt[0] + adcrd_pkg::RCR_ONE >= repeat_count_limit[0] |=> s_reg.rdy[0])
    else $error("ready not raised at repeat limit");

  a_asleep_current: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sc_valid[0] && cpu_off && !s_reg.rdy[0] |=> s_reg.res[0] == $past(sc_res[0]))
    else $error("result not current while processor off");

  a_req_needs_en: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !s_reg.dreq[0] && !dma_rd_en[0] |=> !s_reg.dreq[0])
    else $error("result request raised with DMA off");

  a_wr_req_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !dma_wr_en[0] |=> !s_reg.wreq[0])
    else $error("control request raised with DMA off");

  a_sw_ctrl_wins: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sw_ctrl_we[1] |=> s_reg.ctrl[1] == $past(sw_ctrl_data))
    else $error("software control write lost");
endmodule

`default_nettype wire

// file: verilog/adcrd_scale.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Result scaler: clamp, code, gain compensation, gross detect
// ****************************************************************
module adcrd_scale (
  input wire logic sys_clk,                              // System clock
  input wire logic rst_n,                                // Async reset, low
  input wire logic raw_valid,                            // New raw word
  input wire logic signed [adcrd_pkg::RAW_W-1:0] raw,    // Raw modulator word
  input wire logic unipolar,                             // Coding select
  input wire logic [adcrd_pkg::GAIN_W-1:0] gain_log2,    // Amplifier gain
  output logic res_valid,                                // Scaled word ready
  output logic [adcrd_pkg::RES_W-1:0] res,               // Scaled result
  output logic gross                                     // Gross over/under
);
  typedef struct packed {
    logic valid;
    logic [adcrd_pkg::RES_W-1:0] res;
    logic gross;
  } adcrd_scale_t;

  adcrd_scale_t s_reg;
  adcrd_scale_t s_next;
  logic signed [adcrd_pkg::RAW_W-1:0] clamped;
  logic signed [adcrd_pkg::RES_W-1:0] wide;
  localparam int RES_W = adcrd_pkg::RES_W;

  // Clamp to the 24-bit code, then shift so one count is Vref/2^28
  always_comb
  begin
    s_next = s_reg;
    s_next.valid = raw_valid;
    clamped = raw;
    if (unipolar)
    begin
      if (raw > adcrd_pkg::UNI_MAX) clamped = adcrd_pkg::UNI_MAX;
      if (raw < adcrd_pkg::UNI_MIN) clamped = adcrd_pkg::UNI_MIN;
    end
    else
    begin
      if (raw > adcrd_pkg::BIP_MAX) clamped = adcrd_pkg::BIP_MAX;
      if (raw < adcrd_pkg::BIP_MIN) clamped = adcrd_pkg::BIP_MIN;
    end
    wide = RES_W'(clamped) <<< adcrd_pkg::ALIGN_SHIFT;
    // Dividing by the gain here keeps software free of gain correction
    if (raw_valid)
    begin
      s_next.res = unipolar ? (wide >> gain_log2) : (wide >>> gain_log2);
      s_next.gross = unipolar ? (raw > adcrd_pkg::UNI_HI || raw < adcrd_pkg::UNI_LO)
                              : (raw > adcrd_pkg::BIP_HI || raw < adcrd_pkg::BIP_LO);
    end
    else
      s_next.gross = 1'b0;
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign res_valid = s_reg.valid;
  assign res = s_reg.res;
  assign gross = s_reg.gross;
endmodule

`default_nettype wire

// file: tb/adcrd_dma_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// DMA controller stand-in: answers result and control requests
// ****************************************************************
module adcrd_dma_model (
  input wire logic sys_clk,                             // System clock
  input wire logic rst_n,                               // Async reset, low
  input wire logic [2:0] dma_rd_req,                    // Result requests
  input wire logic [1:0] dma_wr_req,                    // Control requests
  input wire logic [2:0][31:0] conversion_result_reg,   // Results
  input wire logic [3:0] ack_delay,                     // Wait before answer
  input wire logic [19:0] wr_word,                      // Word for control DMA
  output logic [2:0] dma_rd_ack,                        // Result word taken
  output logic [1:0] dma_wr_ack,                        // Control word given
  output logic [19:0] dma_wr_data,                      // Control data
  output logic [31:0] dma_word                          // Last word to memory
);
  logic [4:0] req;
  logic [4:0] ack_reg;
  logic [4:0][3:0] cnt;
  // Requests of both paths side by side, results low
  assign req = {dma_wr_req, dma_rd_req};
  assign dma_rd_ack = ack_reg[2:0];
  assign dma_wr_ack = ack_reg[4:3];
  // Data is only good in the ack cycle, so it shows the inverse otherwise
  assign dma_wr_data = (ack_reg[4:3] != 2'h0) ? wr_word : ~wr_word;
  // One ack per request, after a programmable wait, never twice in a row
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_reg <= '0;
      cnt <= '0;
      dma_word <= '0;
    end
    else
    begin
      for (int i = 0; i < 5; i++)
      begin
        if (ack_reg[i])
        begin
          ack_reg[i] <= 1'b0;
          cnt[i] <= 4'h0;
        end
        else if (req[i] && cnt[i] == ack_delay)
        begin
          ack_reg[i] <= 1'b1;
          // Word is taken only while the request, and so the ready flag, is up
          if (i < 3) dma_word <= conversion_result_reg[i];
        end
        else if (req[i]) cnt[i] <= cnt[i] + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

// ****************************************************************
// Result path bench
// ****************************************************************
module tb;
  logic sys_clk, rst_n, power_down, cpu_off, rd_strobe;
  logic [2:0] raw_valid, dma_rd_en, dma_rd_ack, result_ready, result_error, dma_rd_req;
  logic [2:0][25:0] raw;
  logic [1:0][2:0] pga_gain;
  logic [1:0][15:0] repeat_count_limit, filter_cfg;
  logic [1:0] conv_start_in, sw_ctrl_we, dma_wr_en, dma_wr_ack, dma_wr_req, conv_start_out;
  logic [1:0] rd_sel;
  logic [15:0] common_converter_config, filter_applied0;
  logic [19:0] sw_ctrl_data, dma_wr_data, wr_word;
  logic [1:0][19:0] converter_control_reg;
  logic [2:0][31:0] conversion_result_reg;
  logic [31:0] rd_data, dma_word;
  logic [3:0] ack_delay;
  logic [31:0] exp_q[$];
  int fail_count, checks;
  adcrd_path DUT (.sys_clk, .rst_n, .raw_valid, .raw, .pga_gain, .repeat_count_limit,
    .filter_cfg, .conv_start_in, .common_converter_config, .power_down, .cpu_off,
    .rd_strobe, .rd_sel, .sw_ctrl_we, .sw_ctrl_data, .dma_rd_en, .dma_rd_ack, .dma_wr_en,
    .dma_wr_ack, .dma_wr_data, .conversion_result_reg, .result_ready, .result_error,
    .rd_data, .dma_rd_req, .dma_wr_req, .converter_control_reg, .filter_applied0,
    .conv_start_out);
  adcrd_dma_model dma (.sys_clk, .rst_n, .dma_rd_req, .dma_wr_req, .conversion_result_reg,
    .ack_delay, .wr_word, .dma_rd_ack, .dma_wr_ack, .dma_wr_data, .dma_word);
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Expected word: clamp to the 24-bit code, put on the 2^28 scale, undo gain
  function automatic logic [31:0] scl(logic signed [25:0] r, logic u, logic [2:0] g);
    logic signed [31:0] w;
    w = 32'(r);
    if (u) w = (w < 0) ? 32'sh0 : ((w > 32'sh0FFFFFF) ? 32'sh0FFFFFF : w);
    else w = (w > 32'sh07FFFFF) ? 32'sh07FFFFF : ((w < -32'sh0800000) ? -32'sh0800000 : w);
    w = w <<< 4;
    if (u) return $unsigned(w) >> g;
    return w >>> g;
  endfunction
  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Reset pulse; also used in mid-run to clear the repeat counters
  task automatic rst();
    @(posedge sys_clk) rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    #1;
    `CHK(converter_control_reg, {adcrd_pkg::CTRL1_RST, adcrd_pkg::CTRL0_RST})
    `CHK({result_ready, result_error, dma_rd_req}, 9'h000)
  endtask
  // Raw word pulse; returns once the result edge has landed
  task automatic conv(int c, logic signed [25:0] r);
    @(posedge sys_clk) raw_valid <= 3'(1 << c);
    raw[c] <= r;
    @(posedge sys_clk) raw_valid <= 3'h0;
    cyc(2);
    #1;
  endtask
  // Processor read; the monitor below compares the answer
  task automatic rd(int c, logic [31:0] e);
    @(posedge sys_clk) rd_strobe <= 1'b1;
    rd_sel <= 2'(c);
    exp_q.push_back(e);
    @(posedge sys_clk) rd_strobe <= 1'b0;
    cyc(1);
    #1;
    `CHK(result_ready[c], 1'b0)
  endtask
  // Bounded wait for the controller's ack on a read or write path
  task automatic wack(int c, bit w);
    int i;
    for (i = 0; i < 50; i++)
    begin
      @(posedge sys_clk);
      if ((w ? dma_wr_ack[c] : dma_rd_ack[c]) === 1'b1) break;
    end
    #1;
    if (i == 50)
    begin
      fail_count++;
      tally_and_finish();
    end
  endtask
  // Read data is one cycle behind the strobe edge
  initial
  begin
    forever
    begin
      @(posedge sys_clk);
      if (rd_strobe === 1'b1)
      begin
        @(posedge sys_clk);
        #1;
        `CHK(rd_data, exp_q.pop_front())
      end
    end
  end
  initial
  begin
    logic signed [25:0] r;
    {raw_valid, raw, pga_gain, repeat_count_limit, filter_cfg, conv_start_in} = '0;
    {common_converter_config, power_down, cpu_off, rd_strobe, rd_sel, sw_ctrl_we} = '0;
    {sw_ctrl_data, dma_rd_en, dma_wr_en, fail_count, checks, rst_n} = '0;
    ack_delay = 4'h2;
    wr_word = 20'hBC1AC;
    r = 26'($urandom(68));
    rst();
    // Converter 1 to unipolar coding through a software write
    @(posedge sys_clk) sw_ctrl_we <= 2'h2;
    sw_ctrl_data <= adcrd_pkg::CTRL1_RST | 20'h40000;
    @(posedge sys_clk) sw_ctrl_we <= 2'h0;
    // Every gain, both codings, and the step channel at unity gain
    for (int g = 0; g < 8; g++)
    begin
      @(posedge sys_clk) pga_gain <= {2{3'(g)}};
      r = 26'($signed($urandom) >>> 9);
      conv(0, r);
      `CHK(result_ready[0], 1'b1)
      rd(0, scl(r, 1'b0, 3'(g)));
      conv(2, r);
      rd(2, scl(r, 1'b0, 3'h0));
      r = 26'($urandom_range(24'hFFFFFF, 0));
      conv(1, r);
      rd(1, scl(r, 1'b1, 3'(g)));
    end
    conv(1, -26'sh100);
    rd(1, 32'h0);
    @(posedge sys_clk) pga_gain <= '0;
    // Gross limit: exactly at the limit is clean, one beyond sets the error
    for (int k = 0; k < 2; k++)
    begin
      conv(0, adcrd_pkg::BIP_HI + 26'(k));
      `CHK(result_error[0], 1'(k))
      rd(0, scl(adcrd_pkg::BIP_HI, 1'b0, 3'h0));
    end
    // Second word while ready is up must be dropped
    conv(0, 26'sh1234);
    conv(0, 26'sh5678);
    rd(0, scl(26'sh1234, 1'b0, 3'h0));
    rst();
    // Repeat gating: awake holds the register, asleep keeps it current
    @(posedge sys_clk) repeat_count_limit[0] <= 16'h3;
    for (int i = 1; i < 7; i++)
    begin
      if (i == 4) @(posedge sys_clk) cpu_off <= 1'b1;
      conv(0, 26'(i * 256));
      `CHK(result_ready[0], 1'(i % 3 == 0))
      if (i < 4) `CHK(conversion_result_reg[0], (i == 3) ? scl(26'h300, 1'b0, 3'h0) : 32'h0)
      else `CHK(conversion_result_reg[0], scl(26'(i * 256), 1'b0, 3'h0))
      if (i % 3 == 0) rd(0, scl(26'(i * 256), 1'b0, 3'h0));
    end
    @(posedge sys_clk) repeat_count_limit[0] <= 16'h0;
    cpu_off <= 1'b0;
    // Power-down with DMA: a slow controller, newest word wins
    power_down <= 1'b1;
    dma_rd_en <= 3'h1;
    ack_delay <= 4'hF;
    conv(0, 26'sh11);
    conv(0, 26'sh22);
    `CHK(conversion_result_reg[0], scl(26'sh22, 1'b0, 3'h0))
    wack(0, 1'b0);
    `CHK(dma_word, scl(26'sh22, 1'b0, 3'h0))
    // Result DMA on all three channels, one request per result
    @(posedge sys_clk) power_down <= 1'b0;
    dma_rd_en <= 3'h7;
    ack_delay <= 4'h1;
    for (int c = 0; c < 3; c++)
    begin
      r = 26'($signed($urandom) >>> 9);
      conv(c, r);
      `CHK(dma_rd_req[c], 1'b1)
      wack(c, 1'b0);
      `CHK(dma_word, scl(r, 1'b0, 3'h0))
      `CHK({dma_rd_req[c], result_ready[c]}, 2'h0)
    end
    @(posedge sys_clk) dma_rd_en <= 3'h0;
    // Control DMA into each converter with the supply-monitor words
    for (int k = 0; k < 2; k++)
    begin
      @(posedge sys_clk) wr_word <= k ? 20'hBC1CC : 20'hBC1AC;
      dma_wr_en <= 2'(1 << k);
      wack(k, 1'b1);
      `CHK(converter_control_reg[k], k ? 20'hBC1CC : 20'hBC1AC)
      `CHK(dma_wr_req[k], 1'b0)
      @(posedge sys_clk) dma_wr_en <= 2'h0;
      cyc(2);
    end
    // Simultaneous sampling copies the second converter's filter and start
    @(posedge sys_clk) common_converter_config <= 16'h8000;
    filter_cfg[1] <= 16'($urandom);
    conv_start_in <= 2'h2;
    cyc(3);
    #1;
    `CHK({filter_applied0, conv_start_out}, {filter_cfg[1], 2'h3})
    tally_and_finish();
  end
endmodule
`default_nettype wire
